// *** rtl/mms_memsys.sv ***
`timescale 1ns/10ps
// Functional notes
// - program counter is 13 bits wide
// - decode 0..1119: registers, i/o, sram
// - five data addressing modes supported
// - registers 26..31 form three pointers
// - displacement up to 63 on Y/Z
// - pre-decrement/post-increment write pointer back
// - direct addressing reaches whole data space
// - sram access completes in two cycles
// - separate 512-byte eeprom, byte access
// - eeprom registers live in i/o space
// - software sees write completion by polling
// - eeprom write only via protected sequence
// - eeprom read stalls core four cycles
// - eeprom write stalls core two cycles
// - address bits 15..9 read zero
// - nine address bits select byte 0..511
// - address undefined after reset; software loads
// - data register supplies byte to write
// - read fills data register from address
// - master enable clears after four cycles
// - strobe without master enable does nothing
// - busy: strobe stays set, address frozen
// - read data ready for next instruction
module mms_memsys #(
	parameter int unsigned EE_WRITE_CYCLES_P = mms_pkg::EE_WRITE_CYCLES
) (
	input  wire logic                     CLK,
	input  wire logic                     RST,
	input  wire logic                     DS_VALID,
	input  wire mms_pkg::mms_req_t        DS_REQ,
	input  wire logic                     PC_LOAD,
	input  wire logic [mms_pkg::PC_W-1:0] PC_TARGET,
	input  wire logic                     PC_STEP,
	output logic      [7:0]               DS_RDATA,
	output logic                          DS_DONE,
	output logic                          CORE_STALL,
	output logic      [mms_pkg::PC_W-1:0] PROGRAM_COUNTER
);
	import mms_pkg::*;

	localparam int unsigned CNT_W = $clog2(EE_WRITE_CYCLES_P + 1);

	typedef enum logic {
		ST_IDLE,
		ST_ACC
	} mms_state_t;

	mms_state_t           state_ff;
	mms_req_t             req_ff;
	logic [15:0]          ea_ff;
	logic [7:0]           rf_mem   [RF_SIZE];
	logic [7:0]           io_mem   [IO_SIZE];
	logic [7:0]           sram_mem [SRAM_SIZE];
	logic [7:0]           ee_mem   [EE_SIZE];
	logic [EE_ADDR_W-1:0] ee_addr_ff;
	logic [7:0]           ee_data_ff;
	logic                 mwe_ff;
	logic [2:0]           mwe_cnt_ff;
	logic                 busy_ff;
	logic [CNT_W-1:0]     wcnt_ff;
	logic [2:0]           stall_cnt_ff;
	logic                 done_ff;
	logic [7:0]           rdata_ff;
	logic                 stall_ff;
	logic [PC_W-1:0]      pc_ff;

	logic                 req_take;
	logic                 acc_fire;
	logic [15:0]          ptr_val;
	logic [15:0]          nxt_ea;
	logic                 is_rf;
	logic                 is_io;
	logic                 is_sram;
	logic [4:0]           rf_idx;
	logic [5:0]           io_idx;
	logic [9:0]           sram_idx;
	logic                 io_wr;
	logic                 ctrl_wr;
	logic                 mwe_set;
	logic                 ee_wr_go;
	logic                 ee_rd_go;
	logic [7:0]           io_rd;

	function automatic logic [15:0] ptr_of(input mms_ptr_t sel, input logic [7:0] r26, input logic [7:0] r27,
	                                       input logic [7:0] r28, input logic [7:0] r29,
	                                       input logic [7:0] r30, input logic [7:0] r31);
		logic [15:0] v;
		unique case (sel)
			PS_X: v = {r27, r26};
			PS_Y: v = {r29, r28};
			default: v = {r31, r30};
		endcase
		return v;
	endfunction

	function automatic logic [4:0] ptr_lo(input mms_ptr_t sel);
		logic [4:0] v;
		unique case (sel)
			PS_X: v = PTR_X_LO;
			PS_Y: v = PTR_Y_LO;
			default: v = PTR_Z_LO;
		endcase
		return v;
	endfunction

	// a request is taken only when idle and the core is not held
	assign req_take = DS_VALID && (state_ff == ST_IDLE) && !stall_ff;
	assign acc_fire = (state_ff == ST_ACC);

	// pointer pairs sit in registers 26..31
	assign ptr_val = ptr_of(DS_REQ.ptr, rf_mem[26], rf_mem[27], rf_mem[28],
	                        rf_mem[29], rf_mem[30], rf_mem[31]);

	always_comb begin
		nxt_ea = DS_REQ.addr;
		unique case (DS_REQ.mode)
			AM_DIRECT: nxt_ea = DS_REQ.addr;
			AM_DISP: nxt_ea = ptr_val + ((DS_REQ.ptr == PS_X) ? 16'h0000 : {10'h000, DS_REQ.disp});
			AM_INDIRECT: nxt_ea = ptr_val;
			AM_PREDEC: nxt_ea = ptr_val - 16'h0001;
			AM_POSTINC: nxt_ea = ptr_val;
			default: nxt_ea = DS_REQ.addr;
		endcase
	end

	// region decode
	assign is_rf    = (ea_ff < IO_BASE);
	assign is_io    = (ea_ff >= IO_BASE) && (ea_ff < SRAM_BASE);
	assign is_sram  = (ea_ff >= SRAM_BASE) && (ea_ff < DATA_END);
	assign rf_idx   = ea_ff[4:0];
	assign io_idx   = 6'(ea_ff - IO_BASE);
	assign sram_idx = 10'(ea_ff - SRAM_BASE);

	assign io_wr    = acc_fire && req_ff.we && is_io;
	assign ctrl_wr  = io_wr && (io_idx == IO_EE_CTRL);
	assign mwe_set  = ctrl_wr && req_ff.wdata[CTRL_MWE_BIT];
	assign ee_wr_go = ctrl_wr && req_ff.wdata[CTRL_WR_BIT] && mwe_ff && !busy_ff;
	assign ee_rd_go = ctrl_wr && req_ff.wdata[CTRL_RD_BIT] && !req_ff.wdata[CTRL_WR_BIT] && !busy_ff;

	always_comb begin
		unique case (io_idx)
			IO_EE_CTRL: io_rd = {5'h00, mwe_ff, busy_ff, 1'b0};
			IO_EE_DATA: io_rd = ee_data_ff;
			IO_EE_ADDR_L: io_rd = ee_addr_ff[7:0];
			IO_EE_ADDR_H: io_rd = {7'h00, ee_addr_ff[8]};
			default: io_rd = io_mem[io_idx];
		endcase
	end

	// access sequencer: take, then one access cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_ff <= ST_IDLE;
			req_ff   <= '0;
			ea_ff    <= 16'h0000;
		end else begin
			if (req_take) begin
				state_ff <= ST_ACC;
				req_ff   <= DS_REQ;
				ea_ff    <= nxt_ea;
			end else if (acc_fire) begin
				state_ff <= ST_IDLE;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			done_ff  <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			done_ff <= acc_fire;
			if (acc_fire && !req_ff.we) begin
				if (is_rf)
					rdata_ff <= rf_mem[rf_idx];
				else if (is_io)
					rdata_ff <= io_rd;
				else if (is_sram)
					rdata_ff <= sram_mem[sram_idx];
				else
					rdata_ff <= 8'h00;
			end
		end
	end

	// register file: data writes and pointer write-back
	always_ff @(posedge CLK) begin
		if (acc_fire && req_ff.we && is_rf)
			rf_mem[rf_idx] <= req_ff.wdata;
		if (req_take && (DS_REQ.mode == AM_PREDEC)) begin
			rf_mem[ptr_lo(DS_REQ.ptr)]       <= nxt_ea[7:0];
			rf_mem[ptr_lo(DS_REQ.ptr) + 5'h1] <= nxt_ea[15:8];
		end
		if (acc_fire && (req_ff.mode == AM_POSTINC)) begin
			rf_mem[ptr_lo(req_ff.ptr)]       <= 8'(ea_ff + 16'h0001);
			rf_mem[ptr_lo(req_ff.ptr) + 5'h1] <= 8'((ea_ff + 16'h0001) >> 8);
		end
	end

	always_ff @(posedge CLK) begin
		if (io_wr)
			io_mem[io_idx] <= req_ff.wdata;
	end

	always_ff @(posedge CLK) begin
		if (acc_fire && req_ff.we && is_sram)
			sram_mem[sram_idx] <= req_ff.wdata;
	end

	// eeprom address: no reset, software must load it; frozen while busy
	always_ff @(posedge CLK) begin
		if (io_wr && !busy_ff && (io_idx == IO_EE_ADDR_L))
			ee_addr_ff[7:0] <= req_ff.wdata;
		if (io_wr && !busy_ff && (io_idx == IO_EE_ADDR_H))
			ee_addr_ff[8] <= req_ff.wdata[0];
	end

	// data byte: software write or eeprom fetch
	always_ff @(posedge CLK) begin
		if (ee_rd_go)
			ee_data_ff <= ee_mem[ee_addr_ff];
		else if (io_wr && (io_idx == IO_EE_DATA))
			ee_data_ff <= req_ff.wdata;
	end

	always_ff @(posedge CLK) begin
		if (ee_wr_go)
			ee_mem[ee_addr_ff] <= ee_data_ff;
	end

	// master write enable: a new set wins over the timeout
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mwe_ff     <= 1'b0;
			mwe_cnt_ff <= 3'h0;
		end else begin
			if (mwe_set) begin
				mwe_ff     <= 1'b1;
				mwe_cnt_ff <= MWE_HOLD_CYC;
			end else if (mwe_cnt_ff != 3'h0) begin
				mwe_cnt_ff <= mwe_cnt_ff - 3'h1;
				mwe_ff     <= (mwe_cnt_ff > 3'h1);
			end
		end
	end

	// self-timed write period
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_ff <= 1'b0;
			wcnt_ff <= '0;
		end else begin
			if (ee_wr_go) begin
				busy_ff <= 1'b1;
				wcnt_ff <= CNT_W'(EE_WRITE_CYCLES_P);
			end else if (busy_ff) begin
				wcnt_ff <= wcnt_ff - CNT_W'(1);
				if (wcnt_ff == CNT_W'(1))
					busy_ff <= 1'b0;
			end
		end
	end

	// core hold after an eeprom trigger
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stall_cnt_ff <= 3'h0;
			stall_ff     <= 1'b0;
		end else begin
			if (ee_rd_go) begin
				stall_cnt_ff <= RD_STALL_CYC;
				stall_ff     <= 1'b1;
			end else if (ee_wr_go) begin
				stall_cnt_ff <= WR_STALL_CYC;
				stall_ff     <= 1'b1;
			end else if (stall_cnt_ff != 3'h0) begin
				stall_cnt_ff <= stall_cnt_ff - 3'h1;
				stall_ff     <= (stall_cnt_ff > 3'h1);
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			pc_ff <= '0;
		else if (PC_LOAD)
			pc_ff <= PC_TARGET;
		else if (PC_STEP && !stall_ff)
			pc_ff <= pc_ff + PC_W'(1);
	end

	assign DS_RDATA        = rdata_ff;
	assign DS_DONE         = done_ff;
	assign CORE_STALL      = stall_ff;
	assign PROGRAM_COUNTER = pc_ff;

	sequence s_rd_hold;
		stall_ff [*4] ##1 !stall_ff;
	endsequence

	sequence s_wr_hold;
		stall_ff [*2] ##1 !stall_ff;
	endsequence

	sequence s_mwe_quiet;
		mwe_set ##1 !mwe_set [*4];
	endsequence

	access_two_a: assert property (@(posedge CLK) disable iff (RST)
		req_take |=> !done_ff ##1 done_ff)
		else $error("data access did not finish in two cycles");

	read_hold_a: assert property (@(posedge CLK) disable iff (RST)
		ee_rd_go |=> s_rd_hold)
		else $error("eeprom read hold is not four cycles");

	write_hold_a: assert property (@(posedge CLK) disable iff (RST)
		ee_wr_go |=> s_wr_hold)
		else $error("eeprom write hold is not two cycles");

	mwe_timeout_a: assert property (@(posedge CLK) disable iff (RST)
		mwe_set |=> mwe_ff [*4])
		else $error("master write enable dropped early");

	mwe_clear_a: assert property (@(posedge CLK) disable iff (RST)
		s_mwe_quiet |=> !mwe_ff)
		else $error("master write enable not cleared after four cycles");

	no_mwe_write_a: assert property (@(posedge CLK) disable iff (RST)
		(ctrl_wr && req_ff.wdata[CTRL_WR_BIT] && !mwe_ff && !busy_ff) |=> !busy_ff)
		else $error("write started without master enable");

	busy_addr_a: assert property (@(posedge CLK) disable iff (RST)
		busy_ff |=> $stable(ee_addr_ff))
		else $error("eeprom address changed during write");

	unmapped_zero_a: assert property (@(posedge CLK) disable iff (RST)
		(acc_fire && !req_ff.we && (ea_ff >= DATA_END)) |=> (rdata_ff == 8'h00))
		else $error("unmapped read returned nonzero");

	postinc_back_a: assert property (@(posedge CLK) disable iff (RST)
		(acc_fire && (req_ff.mode == AM_POSTINC) && !(req_ff.we && is_rf))
		|=> (ptr_of($past(req_ff.ptr), rf_mem[26], rf_mem[27], rf_mem[28], rf_mem[29], rf_mem[30], rf_mem[31])
		     == $past(ea_ff) + 16'h0001))
		else $error("post-increment pointer not written back");

	read_fetch_a: assert property (@(posedge CLK) disable iff (RST)
		ee_rd_go |=> (ee_data_ff == $past(ee_mem[ee_addr_ff])))
		else $error("eeprom read fetched wrong byte");

	addr_high_a: assert property (@(posedge CLK) disable iff (RST)
		(acc_fire && !req_ff.we && is_io && (io_idx == IO_EE_ADDR_H)) |=> (rdata_ff[7:1] == 7'h00))
		else $error("unimplemented address bits read nonzero");

endmodule

// *** rtl/mms_pkg.sv ***
package mms_pkg;

	// program space
	localparam int unsigned PC_W          = 13;

	// data space layout
	localparam int unsigned DADDR_W       = 16;
	localparam logic [15:0] RF_BASE       = 16'h0000;
	localparam logic [15:0] IO_BASE       = 16'h0020;
	localparam logic [15:0] SRAM_BASE     = 16'h0060;
	localparam logic [15:0] DATA_END      = 16'h0460;
	localparam int unsigned RF_SIZE       = 32;
	localparam int unsigned IO_SIZE       = 64;
	localparam int unsigned SRAM_SIZE     = 1024;

	// pointer pairs, low byte index
	localparam logic [4:0]  PTR_X_LO      = 5'h1a;
	localparam logic [4:0]  PTR_Y_LO      = 5'h1c;
	localparam logic [4:0]  PTR_Z_LO      = 5'h1e;
	localparam int unsigned DISP_W        = 6;

	// eeprom access registers, as i/o register numbers
	localparam logic [5:0]  IO_EE_CTRL    = 6'h1c;
	localparam logic [5:0]  IO_EE_DATA    = 6'h1d;
	localparam logic [5:0]  IO_EE_ADDR_L  = 6'h1e;
	localparam logic [5:0]  IO_EE_ADDR_H  = 6'h1f;

	// control register field positions
	localparam int unsigned CTRL_MWE_BIT  = 2;
	localparam int unsigned CTRL_WR_BIT   = 1;
	localparam int unsigned CTRL_RD_BIT   = 0;

	// eeprom array
	localparam int unsigned EE_SIZE       = 512;
	localparam int unsigned EE_ADDR_W     = 9;

	// timing
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned EE_WRITE_TIME_NS = 8500000;
	localparam int unsigned EE_WRITE_CYCLES =
		(EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  MWE_HOLD_CYC  = 3'h4;
	localparam logic [2:0]  RD_STALL_CYC  = 3'h4;
	localparam logic [2:0]  WR_STALL_CYC  = 3'h2;

	typedef enum logic [2:0] {
		AM_DIRECT,
		AM_DISP,
		AM_INDIRECT,
		AM_PREDEC,
		AM_POSTINC
	} mms_mode_t;

	typedef enum logic [1:0] {
		PS_X,
		PS_Y,
		PS_Z
	} mms_ptr_t;

	typedef struct packed {
		logic              we;
		mms_mode_t         mode;
		mms_ptr_t          ptr;
		logic [DISP_W-1:0] disp;
		logic [15:0]       addr;
		logic [7:0]        wdata;
	} mms_req_t;

endpackage

// *** verif/mms_core_model.sv ***
`timescale 1ns/10ps
module mms_core_model (
	input  wire logic              clk,
	input  wire logic              ds_done,
	input  wire logic              core_stall,
	input  wire logic [7:0]        ds_rdata,
	output logic                   ds_valid,
	output mms_pkg::mms_req_t      ds_req
);
	import mms_pkg::*;
	int idle_gap = 0;
	initial begin
		ds_valid = 1'b0;
		ds_req = '0;
	end
	// called at a rising edge, returns at the edge where done is sampled
	task automatic access(input logic we, input mms_mode_t md, input mms_ptr_t pt, input logic [5:0] dp,
		input logic [15:0] ad, input logic [7:0] wd, output logic [7:0] rd, output int lat);
		int n;
		n = 0;
		repeat (idle_gap) @(posedge clk);
		while (core_stall !== 1'b0 && n < 64) begin
			@(posedge clk);
			n++;
		end
		ds_req <= '{we, md, pt, dp, ad, wd};
		ds_valid <= 1'b1;
		@(posedge clk);
		ds_valid <= 1'b0;
		// released request lines carry garbage, not the old value
		ds_req <= mms_req_t'(~ds_req);
		lat = 0;
		while (lat < 9 && ds_done !== 1'b1) begin
			@(posedge clk);
			lat++;
		end
		rd = ds_rdata;
	endtask
endmodule

// *** verif/mms_memsys_tb.sv ***
`timescale 1ns/10ps
module mms_memsys_tb;
	import mms_pkg::*;
	logic              clk, rst, pc_load, pc_step, ds_valid, ds_done, core_stall;
	logic [PC_W-1:0]   pc_target, pc;
	mms_req_t          ds_req;
	logic [7:0]        ds_rdata, rd, d;
	logic [15:0]       a, b, t, nb;
	logic [8:0]        ea;
	logic [5:0]        dp;
	int                mismatches = 0, check_count = 0, lat, n, run = 0, last_run = 0;
	logic [7:0]        mem [int];
	logic [15:0]       corner [8] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h045f, 16'h0460, 16'hffff};

	mms_memsys #(.EE_WRITE_CYCLES_P(20)) DUT (.CLK(clk), .RST(rst), .DS_VALID(ds_valid), .DS_REQ(ds_req),
		.PC_LOAD(pc_load), .PC_TARGET(pc_target), .PC_STEP(pc_step), .DS_RDATA(ds_rdata), .DS_DONE(ds_done),
		.CORE_STALL(core_stall), .PROGRAM_COUNTER(pc));
	mms_core_model core (.clk(clk), .ds_done(ds_done), .core_stall(core_stall), .ds_rdata(ds_rdata),
		.ds_valid(ds_valid), .ds_req(ds_req));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// length of the last stall run
	always @(posedge clk) begin
		if (core_stall === 1'b1) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_run <= run;
			run <= 0;
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic we, input mms_mode_t m, input mms_ptr_t p, input logic [5:0] dq,
		input logic [15:0] ad, input logic [7:0] wd);
		core.access(we, m, p, dq, ad, wd, rd, lat);
		chk(16'(lat), 16'h0002);
		if (lat > 8) complete_run();
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] wd);
		acc(1'b1, AM_DIRECT, PS_X, 6'h00, ad, wd);
	endtask
	task automatic rdd(input logic [15:0] ad, input logic [7:0] e);
		acc(1'b0, AM_DIRECT, PS_X, 6'h00, ad, 8'h00);
		chk({8'h00, rd}, {8'h00, e});
	endtask
	function automatic logic [15:0] tgt(mms_ptr_t p, mms_mode_t m, logic [15:0] bs, logic [5:0] dq);
		if (m == AM_PREDEC) return bs - 16'h0001;
		if (m == AM_DISP && p != PS_X) return bs + {10'h000, dq};
		return bs;
	endfunction
	function automatic logic [15:0] nptr(mms_mode_t m, logic [15:0] bs);
		if (m == AM_PREDEC) return bs - 16'h0001;
		if (m == AM_POSTINC) return bs + 16'h0001;
		return bs;
	endfunction

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		pc_load = 1'b0;
		pc_step = 1'b0;
		pc_target = '0;
		void'($urandom(90556));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({pc, ds_done, core_stall, 1'b0}, 16'h0000);
		chk({8'h00, ds_rdata}, 16'h0000);
		rdd(16'h003c, 8'h00);
		// program counter wraps at 13 bits
		n = $urandom_range(2, 9);
		pc_target <= 13'h1ffe;
		pc_load <= 1'b1;
		@(posedge clk);
		pc_load <= 1'b0;
		pc_step <= 1'b1;
		repeat (n) @(posedge clk);
		pc_step <= 1'b0;
		@(posedge clk);
		chk({3'h0, pc}, {3'h0, 13'(13'h1ffe + n)});
		// direct map, boundaries then random, with slow issue
		for (int i = 0; i < 40; i++) begin
			a = (i < 8) ? corner[i] : 16'($urandom_range(0, 16'h047f));
			b = 16'($urandom_range(0, 16'h047f));
			if (a[15:2] == 14'h000f) a = 16'h0060;
			if (b[15:2] == 14'h000f) b = 16'h0061;
			core.idle_gap = $urandom_range(0, 2);
			d = 8'($urandom);
			wr(a, d);
			mem[a] = (a < DATA_END) ? d : 8'h00;
			d = 8'($urandom);
			wr(b, d);
			mem[b] = (b < DATA_END) ? d : 8'h00;
			rdd(a, mem[a]);
		end
		core.idle_gap = 0;
		// every pointer with every indirect mode
		for (int p = 0; p < 3; p++) begin
			for (int m = 1; m < 5; m++) begin
				b = 16'($urandom_range(16'h0100, 16'h03f0));
				dp = (p == 2) ? 6'h3f : 6'($urandom);
				t = tgt(mms_ptr_t'(p), mms_mode_t'(m), b, dp);
				d = 8'($urandom);
				wr(t, d);
				wr(16'(PTR_X_LO) + 16'(2 * p), b[7:0]);
				wr(16'(PTR_X_LO) + 16'(2 * p + 1), b[15:8]);
				acc(1'b0, mms_mode_t'(m), mms_ptr_t'(p), dp, 16'h0000, 8'h00);
				chk({8'h00, rd}, {8'h00, d});
				nb = nptr(mms_mode_t'(m), b);
				rdd(16'(PTR_X_LO) + 16'(2 * p), nb[7:0]);
				rdd(16'(PTR_X_LO) + 16'(2 * p + 1), nb[15:8]);
			end
		end
		// eeprom write, read back, refused and timed-out writes
		for (int k = 0; k < 3; k++) begin
			ea = (k == 0) ? 9'h1ff : 9'($urandom);
			d = 8'($urandom);
			wr(16'h003f, {7'($urandom), ea[8]});
			wr(16'h003e, ea[7:0]);
			rdd(16'h003f, {7'h00, ea[8]});
			wr(16'h003d, d);
			wr(16'h003c, 8'h04);
			wr(16'h003c, 8'h02);
			rdd(16'h003c, 8'h02);
			chk(16'(last_run), 16'h0002);
			wr(16'h003e, ~ea[7:0]);
			rdd(16'h003e, ea[7:0]);
			wr(16'h003d, ~d);
			wr(16'h003c, 8'h01);
			rdd(16'h003d, ~d);
			for (n = 0; n < 40; n++) begin
				acc(1'b0, AM_DIRECT, PS_X, 6'h00, 16'h003c, 8'h00);
				if (rd[1] === 1'b0) break;
			end
			chk(16'(n < 40), 16'h0001);
			wr(16'h003d, ~d);
			wr(16'h003c, 8'h01);
			rdd(16'h003d, d);
			chk(16'(last_run), 16'h0004);
			wr(16'h003d, ~d);
			wr(16'h003c, 8'h02);
			rdd(16'h003c, 8'h00);
			wr(16'h003c, 8'h04);
			rdd(16'h003c, 8'h04);
			repeat (4) @(posedge clk);
			wr(16'h003c, 8'h02);
			rdd(16'h003c, 8'h00);
			wr(16'h003c, 8'h01);
			rdd(16'h003d, d);
		end
		complete_run();
	end
endmodule
